// [rtl/lesc_pkg.sv]
/*
  Constants for the per-channel event latch and error counter block:
  register offsets, bit positions, reset values.
  Assumes one channel register page, addressed by its low byte.
*/
// Operation
// - Writing one clears a latched event bit; writing zero leaves it alone.
// - Event bits stay set until cleared, even after the cause ends.
// - First event register bit 6 sets on loopback activate code.
// - First event register bit 5 sets on loopback deactivate code.
// - First event register bit 4 sets on test pattern sync change.
// - First event register bit 3 sets on transmit clock loss event.
// - Bit 2 latches driver short rising edge, or any edge when selected.
// - Bit 1 latches alarm signal rising edge, or any edge when selected.
// - Bit 0 latches signal loss rising edge, or any edge when selected.
// - Second event register bit 6 sets on waveform amplitude overflow.
// - Second event register bit 5 sets on jitter buffer overflow.
// - Second event register bit 4 sets on jitter buffer underflow.
// - Second event register bit 3 sets on test pattern bit error.
// - Second event register bit 2 sets on excessive zeros.
// - Second event register bit 1 sets on code violation; interrupts unless masked.
// - Second event register bit 0 sets on counter overflow; interrupts unless masked.
// - Counter low byte register reads counter bits 7 to 0, resets zero.
// - Bit 7 of each event register reserved; all event bits reset zero.
// - Counter high byte register reads counter bits 15 to 8.
// - Interrupt only when source enable is one; edge select picks trigger.
package lesc_pkg;

  // Register offsets within the channel page
  localparam logic [7:0] LESC_ADDR_EVT_A  = 8'h3a;
  localparam logic [7:0] LESC_ADDR_EVT_B  = 8'h3b;
  localparam logic [7:0] LESC_ADDR_CNT_LO = 8'h3c;
  localparam logic [7:0] LESC_ADDR_CNT_HI = 8'h3d;

  // First event register bits
  localparam int LESC_A_LOOP_ACT   = 6;
  localparam int LESC_A_LOOP_DEACT = 5;
  localparam int LESC_A_PAT_SYNC   = 4;
  localparam int LESC_A_TX_CLK     = 3;
  localparam int LESC_A_DRV_FAIL   = 2;
  localparam int LESC_A_ALARM      = 1;
  localparam int LESC_A_SIG_LOSS   = 0;

  // Second event register bits
  localparam int LESC_B_WAVE_OVF   = 6;
  localparam int LESC_B_JIT_OVF    = 5;
  localparam int LESC_B_JIT_UNF    = 4;
  localparam int LESC_B_PAT_ERR    = 3;
  localparam int LESC_B_EXZ        = 2;
  localparam int LESC_B_CODE_VIOL  = 1;
  localparam int LESC_B_CNT_OVF    = 0;

  // Reserved bit and reset values
  localparam int               LESC_RSVD_BIT   = 7;
  localparam logic [7:0]       LESC_EVT_RST    = 8'h00;
  localparam logic [7:0]       LESC_RDATA_RST  = 8'h00;
  localparam logic [7:0]       LESC_UNMAPPED   = 8'h00;
  localparam logic [15:0]      LESC_CNT_RST    = 16'h0000;
  localparam logic [15:0]      LESC_CNT_MAX    = 16'hffff;
  localparam logic [15:0]      LESC_CNT_ONE    = 16'h0001;
  localparam logic [7:0]       LESC_EVT_MASK   = 8'h7f;

endpackage

// [rtl/lesc_cnt_if.sv]
/*
  Carrier between the event latch block and its error counter.
  Assumes both ends run on mclk.
*/
`timescale 1ns/10ps
interface lesc_cnt_if;
  logic        count_pulse;
  logic [15:0] count;
  logic        wrap;

  modport counter (input count_pulse, output count, output wrap);
  modport user    (output count_pulse, input count, input wrap);
endinterface

// [rtl/lesc_err_counter.sv]
/*
  Sixteen-bit error counter with a one-cycle wrap pulse.
  Assumes count_pulse is a one-cycle pulse on mclk.
*/
`timescale 1ns/10ps
module lesc_err_counter
  import lesc_pkg::*;
(
  // Clock and reset
  input wire logic      mclk,
  input wire logic      rst,
  // Counter carrier
  lesc_cnt_if.counter   cnt
);

  typedef struct packed {
    logic [15:0] count;
    logic        wrap;
  } lesc_cnt_s;

  lesc_cnt_s state;
  lesc_cnt_s next_state;

  // Count up, flag the wrap from all ones to zero
  always_comb begin
    next_state      = state;
    next_state.wrap = 1'b0;
    if (cnt.count_pulse) begin
      next_state.count = state.count + LESC_CNT_ONE;
      next_state.wrap  = (state.count == LESC_CNT_MAX);
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= '{count: LESC_CNT_RST, wrap: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign cnt.count = state.count;
  assign cnt.wrap  = state.wrap;

endmodule

// [rtl/lesc_event_latch.sv]
/*
  Per-channel sticky event latches, counter byte readback and combined
  interrupt request. Register port: reg_addr with reg_wr or reg_rd pulses.
  Assumes detectors, status bits and register strobes all run on mclk.
*/
`timescale 1ns/10ps
module lesc_event_latch
  import lesc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Detector event pulses
  input  wire logic       loop_activate_det,
  input  wire logic       loop_deactivate_det,
  input  wire logic       pattern_sync_change,
  input  wire logic       tx_clock_loss_det,
  input  wire logic       waveform_overflow_det,
  input  wire logic       jitter_buf_overflow_det,
  input  wire logic       jitter_buf_underflow_det,
  input  wire logic       pattern_error_det,
  input  wire logic       excess_zeros_det,
  input  wire logic       code_violation_det,
  input  wire logic       count_error,
  // Real-time status levels
  input  wire logic       driver_short_status,
  input  wire logic       alarm_signal_status,
  input  wire logic       signal_loss_status,
  // Edge selects and source enables
  input  wire logic       driver_fail_edge_select,
  input  wire logic       alarm_signal_edge_select,
  input  wire logic       signal_loss_edge_select,
  input  wire logic [6:0] irq_enable_a,
  input  wire logic [6:0] irq_enable_b,
  // Interrupt request
  output logic            irq
);

  typedef struct packed {
    logic [7:0] evt_a;
    logic [7:0] evt_b;
    logic [2:0] prev_status;
    logic [7:0] rdata;
    logic       irq;
  } lesc_state_s;

  lesc_state_s state;
  lesc_state_s next_state;
  lesc_cnt_if  cnt ();

  logic [2:0] cur_status;
  logic [2:0] edge_sel;
  logic [2:0] status_hit;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] clr_a;
  logic [7:0] clr_b;

  // Edge qualifier: rising only, or any change when selected
  function automatic logic status_edge(input logic prev, input logic cur, input logic any_change);
    status_edge = any_change ? (prev ^ cur) : (~prev & cur);
  endfunction

  // Error counter
  lesc_err_counter u_counter (
    .mclk (mclk),
    .rst  (rst),
    .cnt  (cnt.counter)
  );
  assign cnt.count_pulse = count_error;

  // Status levels and their edge selects, signal loss in bit 0
  assign cur_status = {driver_short_status, alarm_signal_status, signal_loss_status};
  assign edge_sel   = {driver_fail_edge_select, alarm_signal_edge_select, signal_loss_edge_select};

  // One edge qualifier per status level
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_edge
      assign status_hit[gi] = status_edge(state.prev_status[gi], cur_status[gi], edge_sel[gi]);
    end
  endgenerate

  // Set terms for the first event register
  always_comb begin
    set_a                    = LESC_EVT_RST;
    set_a[LESC_A_LOOP_ACT]   = loop_activate_det;
    set_a[LESC_A_LOOP_DEACT] = loop_deactivate_det;
    set_a[LESC_A_PAT_SYNC]   = pattern_sync_change;
    set_a[LESC_A_TX_CLK]     = tx_clock_loss_det;
    set_a[LESC_A_DRV_FAIL]   = status_hit[2];
    set_a[LESC_A_ALARM]      = status_hit[1];
    set_a[LESC_A_SIG_LOSS]   = status_hit[0];
  end

  // Set terms for the second event register
  always_comb begin
    set_b                   = LESC_EVT_RST;
    set_b[LESC_B_WAVE_OVF]  = waveform_overflow_det;
    set_b[LESC_B_JIT_OVF]   = jitter_buf_overflow_det;
    set_b[LESC_B_JIT_UNF]   = jitter_buf_underflow_det;
    set_b[LESC_B_PAT_ERR]   = pattern_error_det;
    set_b[LESC_B_EXZ]       = excess_zeros_det;
    set_b[LESC_B_CODE_VIOL] = code_violation_det;
    set_b[LESC_B_CNT_OVF]   = cnt.wrap;
  end

  // Write-one-to-clear masks, only for the addressed register
  assign clr_a = (reg_wr && reg_addr == LESC_ADDR_EVT_A) ? reg_wdata : LESC_EVT_RST;
  assign clr_b = (reg_wr && reg_addr == LESC_ADDR_EVT_B) ? reg_wdata : LESC_EVT_RST;

  // Next state: sticky latches where a new event beats a same-cycle clear
  always_comb begin
    next_state             = state;
    next_state.prev_status = cur_status;
    next_state.evt_a = ((state.evt_a & ~clr_a) | set_a) & LESC_EVT_MASK;
    next_state.evt_b = ((state.evt_b & ~clr_b) | set_b) & LESC_EVT_MASK;
    // Request held while any enabled latched bit stays set
    next_state.irq = |({1'b0, irq_enable_a} & next_state.evt_a)
                   | |({1'b0, irq_enable_b} & next_state.evt_b);
    // Read data captured on a read strobe and held until the next read
    if (reg_rd) begin
      unique case (reg_addr)
        LESC_ADDR_EVT_A:  next_state.rdata = state.evt_a;
        LESC_ADDR_EVT_B:  next_state.rdata = state.evt_b;
        LESC_ADDR_CNT_LO: next_state.rdata = cnt.count[7:0];
        LESC_ADDR_CNT_HI: next_state.rdata = cnt.count[15:8];
        default:          next_state.rdata = LESC_UNMAPPED;
      endcase
    end
  end

  // State register; status history starts low so a high level at release counts as a rise
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= '{evt_a: LESC_EVT_RST, evt_b: LESC_EVT_RST, prev_status: 3'h0,
                 rdata: LESC_RDATA_RST, irq: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign irq       = state.irq;

endmodule

// [verif/lesc_sva.sv]
/* Port checker for the event latch block.
   Assumes bind onto lesc_event_latch, all on mclk. */
`timescale 1ns/10ps
module lesc_sva (
  // Clock, reset, register port
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Sources and request
  input wire logic       loop_activate_det,
  input wire logic       code_violation_det,
  input wire logic       alarm_signal_status,
  input wire logic       signal_loss_status,
  input wire logic       alarm_signal_edge_select,
  input wire logic [6:0] irq_enable_a,
  input wire logic [6:0] irq_enable_b,
  input wire logic       irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Reset, reserved bit, source to request
  rst_clear_a: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00 && !irq)
    else $error("reset state");
  rsvd_zero_a: assert property (reg_rd && reg_addr inside {8'h3a, 8'h3b} |=> !reg_rdata[7])
    else $error("reserved bit");
  act_irq_a: assert property (loop_activate_det && irq_enable_a[6] |=> irq)
    else $error("activate irq");
  cv_irq_a: assert property (code_violation_det && irq_enable_b[1] |=> irq)
    else $error("violation irq");
  loss_rise_a: assert property ($rose(signal_loss_status) && irq_enable_a[0] |=> irq)
    else $error("loss irq");
  alarm_fall_a: assert property ($fell(alarm_signal_status) && alarm_signal_edge_select && irq_enable_a[1] |=> irq)
    else $error("alarm irq");
  no_enable_a: assert property (irq_enable_a == 7'h00 && irq_enable_b == 7'h00 |=> !irq)
    else $error("masked irq");
  irq_hold_a: assert property (irq && !reg_wr && $stable(irq_enable_a) && $stable(irq_enable_b) |=> irq)
    else $error("irq dropped");
  // Main scenarios
  cover property (reg_wr && reg_addr == 8'h3b);
  cover property ($fell(irq));
  cover property ($fell(alarm_signal_status) && alarm_signal_edge_select);
endmodule
bind lesc_event_latch lesc_sva lesc_sva_inst (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .loop_activate_det, .code_violation_det, .alarm_signal_status, .signal_loss_status,
  .alarm_signal_edge_select, .irq_enable_a, .irq_enable_b, .irq);

// [verif/lesc_host.sv]
/* Host processor model on the register strobes.
   Assumes the bench calls wr and rd after reset. */
`timescale 1ns/10ps
module lesc_host (
  // Clock and read data
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  // Register strobes
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  // Idle bus
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One write; address and data turn over once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One read; data taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule

// [verif/tb_top.sv]
/* Self-checking bench for the event latch block.
   Assumes the host model and the bound checker. */
`timescale 1ns/10ps
module tb_top;
  logic       mclk, rst, ce, irq, we, re;
  logic [9:0] pv;
  logic [2:0] st, sel;
  logic [6:0] ena, enb;
  logic [7:0] addr, wdata, rdata, r, e;
  logic [16:0] n;
  int         n_fail, checks, i, p;
  lesc_host lesc_host_inst (.mclk(mclk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(we), .reg_rd(re),
    .reg_wdata(wdata));
  lesc_event_latch lesc_event_latch_inst (.mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wr(we), .reg_rd(re),
    .reg_wdata(wdata), .reg_rdata(rdata), .loop_activate_det(pv[0]), .loop_deactivate_det(pv[1]),
    .pattern_sync_change(pv[2]), .tx_clock_loss_det(pv[3]), .waveform_overflow_det(pv[4]),
    .jitter_buf_overflow_det(pv[5]), .jitter_buf_underflow_det(pv[6]), .pattern_error_det(pv[7]),
    .excess_zeros_det(pv[8]), .code_violation_det(pv[9]), .count_error(ce), .driver_short_status(st[2]),
    .alarm_signal_status(st[1]), .signal_loss_status(st[0]), .driver_fail_edge_select(sel[2]),
    .alarm_signal_edge_select(sel[1]), .signal_loss_edge_select(sel[0]), .irq_enable_a(ena),
    .irq_enable_b(enb), .irq(irq));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expected bit of detector i
  function automatic logic [7:0] emask(input int i);
    return 8'h01 << (i < 4 ? 6 - i : 10 - i);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t irq %b want %b", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    lesc_host_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic finish_test;
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    finish_test;
  end
  // Main sequence
  initial begin
    {rst, ce, pv, st, sel, ena, enb} = {1'b1, 31'h0};
    r = 8'h61;
    n_fail = 0;
    checks = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rc(8'h3a, 8'h00);
    rc(8'h3b, 8'h00);
    rc(8'h3c, 8'h00);
    rc(8'h50, 8'h00);
    chk_irq(irq, 1'b0);
    // Each detector, random then full enables
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 10; i++) begin
        r = lfsr(r);
        e = emask(i);
        @(posedge mclk);
        ena <= p ? 7'h7f : r[6:0];
        enb <= p ? 7'h7f : r[7:1];
        pv <= 10'h001 << i;
        @(posedge mclk);
        pv <= 10'h000;
        rc(i < 4 ? 8'h3a : 8'h3b, e);
        chk_irq(irq, |({1'b0, i < 4 ? ena : enb} & e));
        lesc_host_inst.wr(i < 4 ? 8'h3a : 8'h3b, ~e);
        rc(i < 4 ? 8'h3a : 8'h3b, e);
        lesc_host_inst.wr(i < 4 ? 8'h3a : 8'h3b, e);
        rc(i < 4 ? 8'h3a : 8'h3b, 8'h00);
        chk_irq(irq, 1'b0);
      end
    end
    // Masked sources still latch; a new event beats a same-cycle clear
    @(posedge mclk);
    ena <= 7'h00;
    enb <= 7'h00;
    pv <= 10'h3ff;
    @(posedge mclk);
    pv <= 10'h000;
    rc(8'h3a, 8'h78);
    rc(8'h3b, 8'h7e);
    chk_irq(irq, 1'b0);
    fork
      lesc_host_inst.wr(8'h3b, 8'h02);
      begin
        @(posedge mclk);
        pv <= 10'h200;
        @(posedge mclk);
        pv <= 10'h000;
      end
    join
    rc(8'h3b, 8'h7e);
    lesc_host_inst.wr(8'h3a, 8'h7f);
    lesc_host_inst.wr(8'h3b, 8'h7f);
    rc(8'h3a, 8'h00);
    rc(8'h3b, 8'h00);
    @(posedge mclk);
    ena <= 7'h7f;
    enb <= 7'h7f;
    // Status edges, rising only then either way
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 3; i++) begin
        @(posedge mclk);
        sel <= p ? 3'h7 : 3'h0;
        st <= 3'h1 << i;
        rc(8'h3a, 8'h01 << i);
        lesc_host_inst.wr(8'h3a, 8'h01 << i);
        @(posedge mclk);
        st <= 3'h0;
        rc(8'h3a, p ? 8'h01 << i : 8'h00);
        lesc_host_inst.wr(8'h3a, 8'h07);
      end
    end
    // Random count, ignored write, one high byte step, then wrap
    r = lfsr(r);
    n = {9'h0, r};
    @(posedge mclk);
    ce <= 1'b1;
    repeat (n) @(posedge mclk);
    ce <= 1'b0;
    lesc_host_inst.wr(8'h3c, 8'hff);
    rc(8'h3c, r);
    rc(8'h3d, 8'h00);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (256) @(posedge mclk);
    ce <= 1'b0;
    rc(8'h3d, 8'h01);
    rc(8'h3c, r);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (17'h10000 - n - 17'h00100) @(posedge mclk);
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_irq(irq, 1'b1);
    rc(8'h3b, 8'h01);
    rc(8'h3c, 8'h00);
    finish_test;
  end
endmodule
